// >>> src/swd_pkg.sv
package swd_pkg;

  // register byte addresses on the apb bus
  localparam int ADDR_W = 12;
  localparam logic [11:0] WDOG_CTRL_OFS = 12'h80c;
  localparam logic [11:0] CFG_OFS = 12'h810;
  localparam logic [11:0] STAT_OFS = 12'h814;

  // watchdog counter and prescale
  localparam int CNT_W = 24;
  localparam logic [4:0] PRESCALE_MIN_LOG2 = 5'h05;
  localparam logic [4:0] PRESCALE_MAX = 5'h12;
  localparam logic [4:0] PRESCALE_RESET = 5'h0b;

  typedef enum logic [1:0] {
    WDM_OFF = 2'h0,
    WDM_SOFT = 2'h1,
    WDM_AWAKE = 2'h2,
    WDM_ON = 2'h3
  } swd_mode_t;

  // one-bit steps awake -> sleep -> wake; wake -> awake flips both bits
  typedef enum logic [1:0] {
    ST_AWAKE = 2'h0,
    ST_SLEEP = 2'h1,
    ST_WAKE = 2'h3
  } swd_state_t;

  typedef struct packed {
    logic cs;
    logic rsvd;
    logic [4:0] prescale;
    logic soft_en;
  } swd_wdog_ctrl_t;

  typedef struct packed {
    logic lf_force;
    logic mf_force;
    logic hf_force;
    swd_mode_t mode;
  } swd_cfg_t;

  typedef struct packed {
    logic sleeping;
    logic wdog_rst;
    logic tmo;
    logic pwr_dn;
  } swd_stat_t;

  localparam swd_wdog_ctrl_t WDOG_CTRL_RESET = '{cs: 1'b0, rsvd: 1'b0,
                                                 prescale: PRESCALE_RESET, soft_en: 1'b0};
  localparam swd_cfg_t CFG_RESET = '{lf_force: 1'b0, mf_force: 1'b0, hf_force: 1'b0,
                                     mode: WDM_ON};
  localparam logic FLAG_RESET = 1'b1;

endpackage

// >>> src/swd_top.sv
// Behaviour
// - sleep entered only by halt instruction
// - sleep entry clears power-down, sets time-out flag
// - cpu and system clocks stop in sleep
// - oscillators stay on when requested or forced
// - converter runs on rc, else aborts, off
// - ports hold state unless peripheral active
// - listed resets and interrupts wake the device
// - reset sources reset, others resume execution
// - halt prefetches the next instruction
// - enabled interrupt wakes regardless of global enable
// - global enable picks continue or vector after next
// - watchdog cleared on every wake-up
// - pending interrupt, globals off: halt is nop
// - interrupt during halt: sleep then immediate wake
// - watchdog expiry without kick resets device
// - watchdog clock from mid or low oscillator
// - mode 11: watchdog always active
// - mode 10: active awake, off in sleep
// - mode 01: software enable bit controls watchdog
// - mode 00: watchdog off, enable ignored
// - prescale sets period, reset default two seconds
// - counter cleared on reset, kick, sleep, wake, write
// - expiry in sleep wakes, clears three flags
// - prescale doubles from 1:32, reserved gives minimum
`timescale 1ns/1ps
`default_nettype none

module swd_top
  import swd_pkg::*;
#(
  parameter int IRQ_N = 8,
  parameter int PORT_N = 4
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core instructions and interrupt state
  input wire logic halt_instr,
  input wire logic watchdog_kick_instr,
  input wire logic global_irq_enable,
  input wire logic [IRQ_N-1:0] irq_flags,
  input wire logic [IRQ_N-1:0] irq_enables,
  // reset sources, already qualified by their own enables
  input wire logic master_clear_pin,
  input wire logic brownout_reset,
  input wire logic power_on_reset,
  // slow oscillator ticks, one cycle each
  input wire logic mid_freq_osc,
  input wire logic low_freq_osc,
  // peripheral clock requests and activity
  input wire logic lf_osc_req,
  input wire logic mf_osc_req,
  input wire logic hf_osc_req,
  input wire logic converter_rc_osc,
  input wire logic converter_on_bit,
  input wire logic [PORT_N-1:0] port_periph_active,
  // core control
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic prefetch_next,
  output logic resume_exec,
  output logic vector_after_next,
  output logic device_reset,
  // oscillators, converter, ports
  output logic lf_osc_en,
  output logic mf_osc_en,
  output logic hf_osc_en,
  output logic converter_power_en,
  output logic converter_abort,
  output logic [PORT_N-1:0] port_hold,
  // status
  output logic sleeping,
  output logic power_down_flag,
  output logic timeout_status_flag
);

  function automatic logic [CNT_W-1:0] wdt_limit(input logic [4:0] code);
    logic [4:0] sel;
    sel = (code > PRESCALE_MAX) ? 5'h00 : code;
    wdt_limit = CNT_W'((25'h1 << (sel + PRESCALE_MIN_LOG2)) - 25'h1);
  endfunction

  swd_state_t state_r;
  swd_state_t state_nxt;
  swd_wdog_ctrl_t wdog_ctrl_r;
  swd_cfg_t cfg_r;
  swd_stat_t stat;
  logic pwr_dn_r;
  logic tmo_r;
  logic wdog_rst_r;
  logic [CNT_W-1:0] cnt_r;
  logic [31:0] prdata_r;
  logic prefetch_r;
  logic resume_r;
  logic vector_r;
  logic reset_r;
  logic abort_r;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic wr_wdog_ctrl;
  logic wr_cfg;
  logic wr_stat;
  logic pending;
  logic ext_reset_evt;
  logic halt_nop;
  logic enter_sleep;
  logic wake_evt;
  logic wdt_active;
  logic wdt_tick;
  logic timeout;
  logic sleep_timeout;
  logic cnt_clear;

  // apb decode; zero wait states
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign mapped = (paddr == WDOG_CTRL_OFS) || (paddr == CFG_OFS) || (paddr == STAT_OFS);
  assign wr_wdog_ctrl = wr && (paddr == WDOG_CTRL_OFS);
  assign wr_cfg = wr && (paddr == CFG_OFS);
  assign wr_stat = wr && (paddr == STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_r;

  assign stat = '{sleeping: (state_r == ST_SLEEP), wdog_rst: wdog_rst_r, tmo: tmo_r,
                  pwr_dn: pwr_dn_r};

  // read data captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup && !pwrite) begin
      case (paddr)
        WDOG_CTRL_OFS: prdata_r <= {24'h0, wdog_ctrl_r};
        CFG_OFS: prdata_r <= {27'h0, cfg_r};
        STAT_OFS: prdata_r <= {28'h0, stat};
        default: prdata_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_ctrl_r <= WDOG_CTRL_RESET;
    end else if (wr_wdog_ctrl) begin
      wdog_ctrl_r <= '{cs: pwdata[7], rsvd: 1'b0, prescale: pwdata[5:1], soft_en: pwdata[0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= swd_cfg_t'(pwdata[4:0]);
    end
  end

  // wake and halt qualification
  assign pending = |(irq_flags & irq_enables);
  assign ext_reset_evt = master_clear_pin || brownout_reset || power_on_reset;
  assign halt_nop = pending && !global_irq_enable;
  // an awake expiry resets the device, so a halt in that cycle is dropped
  assign enter_sleep = (state_r == ST_AWAKE) && halt_instr && !halt_nop && !ext_reset_evt &&
                       !timeout;
  assign wake_evt = pending || sleep_timeout || ext_reset_evt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_AWAKE: begin
        if (enter_sleep) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: state_nxt = ST_AWAKE;
      default: state_nxt = ST_AWAKE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_AWAKE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // watchdog enable by mode
  always_comb begin
    case (cfg_r.mode)
      WDM_ON: wdt_active = 1'b1;
      WDM_AWAKE: wdt_active = (state_r != ST_SLEEP);
      WDM_SOFT: wdt_active = wdog_ctrl_r.soft_en;
      default: wdt_active = 1'b0;
    endcase
  end

  assign wdt_tick = wdog_ctrl_r.cs ? mid_freq_osc : low_freq_osc;
  assign timeout = wdt_active && wdt_tick &&
                   (cnt_r == wdt_limit(wdog_ctrl_r.prescale));
  assign sleep_timeout = timeout && (state_r == ST_SLEEP);

  // counter clears; the sleep-to-wake edge clears it once more
  assign cnt_clear = ext_reset_evt || (watchdog_kick_instr && state_r != ST_SLEEP) ||
                     enter_sleep || (state_r == ST_SLEEP && wake_evt) ||
                     wr_wdog_ctrl || timeout;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (cnt_clear) begin
      cnt_r <= '0;
    end else if (wdt_active && wdt_tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // flags are active low; hardware clears beat a software set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_dn_r <= FLAG_RESET;
      tmo_r <= FLAG_RESET;
    end else if (sleep_timeout) begin
      pwr_dn_r <= 1'b0;
      tmo_r <= 1'b0;
    end else if (enter_sleep) begin
      pwr_dn_r <= 1'b0;
      tmo_r <= 1'b1;
    end else if (timeout) begin
      tmo_r <= 1'b0;
    end else if (wr_stat) begin
      pwr_dn_r <= pwr_dn_r | pwdata[0];
      tmo_r <= tmo_r | pwdata[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_rst_r <= FLAG_RESET;
    end else if (timeout) begin
      wdog_rst_r <= 1'b0;
    end else if (wr_stat) begin
      wdog_rst_r <= wdog_rst_r | pwdata[2];
    end
  end

  // core handshakes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prefetch_r <= 1'b0;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
    end else begin
      prefetch_r <= (state_r == ST_AWAKE) && halt_instr;
      resume_r <= (state_r == ST_SLEEP) && wake_evt && !ext_reset_evt;
      vector_r <= (state_r == ST_SLEEP) && !ext_reset_evt && pending &&
                  global_irq_enable;
    end
  end

  // expiry while awake and external sources reset the device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_r <= 1'b0;
    end else begin
      reset_r <= ext_reset_evt || (timeout && state_r != ST_SLEEP);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= enter_sleep && converter_on_bit && !converter_rc_osc;
    end
  end

  assign prefetch_next = prefetch_r;
  assign resume_exec = resume_r;
  assign vector_after_next = vector_r;
  assign device_reset = reset_r;
  assign converter_abort = abort_r;
  assign sleeping = stat.sleeping;
  assign power_down_flag = pwr_dn_r;
  assign timeout_status_flag = tmo_r;

  // clocks stop only in the sleep state proper
  assign cpu_clk_en = (state_r != ST_SLEEP);
  assign sys_clk_en = (state_r != ST_SLEEP);

  // watchdog source is kept alive too, or a sleep expiry could never arrive
  assign lf_osc_en = !sleeping || lf_osc_req || cfg_r.lf_force ||
                     (wdt_active && !wdog_ctrl_r.cs);
  assign mf_osc_en = !sleeping || mf_osc_req || cfg_r.mf_force ||
                     (wdt_active && wdog_ctrl_r.cs);
  assign hf_osc_en = !sleeping || hf_osc_req || cfg_r.hf_force;
  assign converter_power_en = converter_on_bit && (!sleeping || converter_rc_osc);
  assign port_hold = sleeping ? ~port_periph_active : '0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence halt_taken;
    state_r == ST_AWAKE && halt_instr && !halt_nop && !ext_reset_evt && !timeout;
  endsequence

  sequence int_wake;
    state_r == ST_SLEEP && pending && !ext_reset_evt && !timeout;
  endsequence

  sequence wake_then_awake;
    state_r == ST_WAKE && resume_exec ##1 state_r == ST_AWAKE;
  endsequence

  AST_SLEEP_ONLY_ON_HALT: assert property (
    $rose(sleeping) |-> $past(halt_instr) && $past(state_r) == ST_AWAKE)
    else $error("sleep entered without halt");

  AST_ENTRY_FLAGS: assert property (
    halt_taken |=> !power_down_flag && timeout_status_flag && sleeping)
    else $error("flags wrong on sleep entry");

  AST_CLOCKS_STOP: assert property (
    sleeping |-> !cpu_clk_en && !sys_clk_en)
    else $error("clock running in sleep");

  AST_CONV_ABORT: assert property (
    halt_taken and (converter_on_bit && !converter_rc_osc)
    |=> converter_abort && !converter_power_en)
    else $error("converter not stopped on sleep");

  AST_HALT_NOP: assert property (
    state_r == ST_AWAKE && halt_instr && halt_nop && !wr_stat && !timeout
    |=> state_r == ST_AWAKE && $stable(power_down_flag) && $stable(timeout_status_flag))
    else $error("halt not treated as nop");

  AST_INT_WAKE: assert property (
    int_wake |=> wake_then_awake)
    else $error("enabled interrupt did not wake");

  AST_WAKE_CLEARS_CNT: assert property (
    state_r == ST_WAKE |-> cnt_r == '0)
    else $error("watchdog not cleared on wake");

  AST_AWAKE_TIMEOUT_RESET: assert property (
    timeout && !sleeping |=> device_reset && !timeout_status_flag && cnt_r == '0)
    else $error("expiry did not reset device");

  AST_MODE_OFF: assert property (
    cfg_r.mode == WDM_OFF |-> !wdt_active ##1 $stable(cnt_r) || cnt_r == '0)
    else $error("watchdog counts in off mode");

  AST_SLEEP_TIMEOUT: assert property (
    sleep_timeout && !ext_reset_evt
    |=> !device_reset && !power_down_flag && !timeout_status_flag && state_r == ST_WAKE)
    else $error("sleep expiry handled wrongly");

endmodule

`default_nettype wire

// >>> tb/swd_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb;
  import swd_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic soft_en;
    logic cs;
    logic [4:0] prescale;
    logic exp;
  } swd_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic halt = 1'b0;
  logic kick = 1'b0;
  logic glb_en = 1'b0;
  logic [7:0] irq_f = '0;
  logic [7:0] irq_e = '0;
  logic pin_rst = 1'b0;
  logic [1:0] rst_src = 2'h0;
  logic osc_req = 1'b0;
  logic mid = 1'b0;
  logic low = 1'b0;
  logic hf_req = 1'b0;
  logic crc = 1'b0;
  logic con = 1'b0;
  logic [3:0] pact = '0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_en, sys_en, pref, resume, vec, dev_rst;
  logic lf_en, mf_en, hf_en, cpow, cabort, slp, pwr_dn, tmo;
  logic [3:0] phold;
  logic [31:0] q;
  logic err;
  logic cs_sel = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  int n_rst = 0;
  int n_res = 0;
  int n_vec = 0;
  int r0, s0, v0, nt;
  // one walk per watchdog setup; wrong clock source shows as early expiry
  swd_row_t rows[8] = '{{2'h3, 1'h0, 1'h0, 5'h00, 1'h1}, {2'h3, 1'h0, 1'h1, 5'h01, 1'h1},
                        {2'h2, 1'h0, 1'h0, 5'h02, 1'h1}, {2'h1, 1'h1, 1'h1, 5'h00, 1'h1},
                        {2'h1, 1'h0, 1'h0, 5'h00, 1'h0}, {2'h0, 1'h1, 1'h0, 5'h00, 1'h0},
                        {2'h3, 1'h0, 1'h0, 5'h13, 1'h1}, {2'h3, 1'h0, 1'h1, 5'h1f, 1'h1}};

  swd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_instr(halt), .watchdog_kick_instr(kick),
    .global_irq_enable(glb_en), .irq_flags(irq_f), .irq_enables(irq_e),
    .master_clear_pin(pin_rst), .brownout_reset(rst_src[0]), .power_on_reset(rst_src[1]),
    .mid_freq_osc(mid), .low_freq_osc(low), .lf_osc_req(osc_req), .mf_osc_req(osc_req),
    .hf_osc_req(hf_req), .converter_rc_osc(crc), .converter_on_bit(con),
    .port_periph_active(pact), .cpu_clk_en(cpu_en), .sys_clk_en(sys_en),
    .prefetch_next(pref), .resume_exec(resume), .vector_after_next(vec),
    .device_reset(dev_rst), .lf_osc_en(lf_en), .mf_osc_en(mf_en), .hf_osc_en(hf_en),
    .converter_power_en(cpow), .converter_abort(cabort), .port_hold(phold),
    .sleeping(slp), .power_down_flag(pwr_dn), .timeout_status_flag(tmo));

  initial begin
    forever #5 pclk = ~pclk;
  end

  // pulses counted at the edge so a one-cycle output is never missed
  always @(posedge pclk) begin
    if (dev_rst === 1'b1) n_rst++;
    if (resume === 1'b1) n_res++;
    if (vec === 1'b1) n_vec++;
  end

  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // selected source ticks every other cycle, the other one every cycle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk);
      mid <= 1'b1;
      low <= 1'b1;
      @(posedge pclk);
      if (cs_sel) mid <= 1'b0;
      else low <= 1'b0;
    end
    @(posedge pclk);
    mid <= 1'b0;
    low <= 1'b0;
  endtask

  task automatic pulse_halt();
    @(posedge pclk);
    halt <= 1'b1;
    @(posedge pclk);
    halt <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    #300000;
    n_fail++;
    end_sim();
  end

  initial begin
    do_reset();
    apb(1'b0, STAT_OFS, '0);
    `CHK("stat", 32'h7, q)
    apb(1'b0, WDOG_CTRL_OFS, '0);
    `CHK("wdog_ctrl", 32'h16, q)
    apb(1'b0, CFG_OFS, '0);
    `CHK("cfg", 32'h3, q)
    apb(1'b0, 12'h800, '0);
    `CHK("unmapped", 33'h1, {q, err})
    foreach (rows[i]) begin
      cs_sel = rows[i].cs;
      nt = (rows[i].prescale > PRESCALE_MAX) ? 32 : (1 << (int'(rows[i].prescale) + 5));
      apb(1'b1, CFG_OFS, {30'h0, rows[i].mode});
      // the control write is what clears the count here
      apb(1'b1, WDOG_CTRL_OFS, {24'h0, rows[i].cs, 1'b0, rows[i].prescale, rows[i].soft_en});
      r0 = n_rst;
      tick(rows[i].exp ? nt - 1 : nt + 4);
      @(negedge pclk);
      `CHK("early", 1'b0, n_rst != r0)
      tick(1);
      repeat (3) @(posedge pclk);
      `CHK("expiry", rows[i].exp, n_rst != r0)
    end
    do_reset();
    irq_f <= 8'h01;
    irq_e <= 8'h01;
    pulse_halt();
    `CHK("nop", 4'b0111, {slp, pwr_dn, tmo, pref})
    @(posedge pclk);
    irq_f <= 8'h00;
    hf_req <= 1'b1;
    con <= 1'b1;
    pact <= 4'b0101;
    apb(1'b1, CFG_OFS, 32'h0b);
    for (int g = 0; g < 2; g++) begin
      glb_en <= g[0];
      crc <= g[0];
      s0 = n_res;
      v0 = n_vec;
      pulse_halt();
      `CHK("enter", 6'b100011, {slp, cpu_en, sys_en, pwr_dn, tmo, pref})
      `CHK("osc", 2'b11, {hf_en, mf_en})
      `CHK("conv", {g[0], ~g[0]}, {cpow, cabort})
      `CHK("ports", 4'b1010, phold)
      @(posedge pclk);
      irq_f <= 8'h01;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      `CHK("wake", 4'b0110, {slp, cpu_en, sys_en, phold[1]})
      `CHK("resume", 1'b1, n_res == s0 + 1)
      `CHK("vector", g[0], n_vec != v0)
      @(posedge pclk);
      irq_f <= 8'h00;
    end
    cs_sel = 1'b0;
    apb(1'b1, CFG_OFS, 32'h3);
    apb(1'b1, WDOG_CTRL_OFS, 32'h0);
    r0 = n_rst;
    s0 = n_res;
    pulse_halt();
    tick(32);
    repeat (3) @(posedge pclk);
    `CHK("sleep_exp", 2'b01, {n_rst != r0, n_res == s0 + 1})
    apb(1'b0, STAT_OFS, '0);
    `CHK("sleep_flags", 32'h0, q)
    apb(1'b1, CFG_OFS, 32'h2);
    pulse_halt();
    tick(40);
    @(negedge pclk);
    `CHK("mode10", 1'b1, slp)
    `CHK("osc_idle", 3'b001, {lf_en, mf_en, hf_en})
    @(posedge pclk);
    osc_req <= 1'b1;
    @(negedge pclk);
    `CHK("osc_req", 2'b11, {lf_en, mf_en})
    s0 = n_res;
    @(posedge pclk);
    osc_req <= 1'b0;
    pin_rst <= 1'b1;
    @(posedge pclk);
    pin_rst <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("pin_wake", 3'b100, {n_rst != r0, n_res != s0, slp})
    // brown-out then power-on, each from sleep
    for (int k = 0; k < 2; k++) begin
      r0 = n_rst;
      pulse_halt();
      @(posedge pclk);
      rst_src <= k ? 2'h2 : 2'h1;
      @(posedge pclk);
      rst_src <= 2'h0;
      repeat (3) @(posedge pclk);
      `CHK("src_wake", 2'b10, {n_rst != r0, slp})
    end
    apb(1'b1, CFG_OFS, 32'h3);
    apb(1'b1, WDOG_CTRL_OFS, 32'h0);
    r0 = n_rst;
    tick(20);
    @(posedge pclk);
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    tick(31);
    `CHK("kick", 1'b0, n_rst != r0)
    tick(1);
    repeat (3) @(posedge pclk);
    `CHK("kick_exp", 1'b1, n_rst != r0)
    end_sim();
  end
endmodule
`default_nettype wire
